// ===== logic/clock_select_regs.svh
// register map, field positions, codes and counts of the system clock source selector
// assumes a 32-bit AHB-Lite slave on hclk and oscillator levels arriving as pins
//
// Notes on behaviour
// - select 00 runs the system clock from the configuration-word default oscillator.
// - select 01 runs CPU and peripherals from the secondary crystal oscillator.
// - select 1x runs from the internal oscillator at internal_freq_select frequency.
// - any reset clears the select field to zero.
// - two-speed start-up and fail-safe switches never change the select field.
// - a new clock is used only after a stabilisation delay.
// - startup_timeout_flag is set only while the configured external source is in use.
// - startup_timeout_flag sets once the start-up timer expires in crystal modes.
// - the start-up timer ignores the secondary oscillator entirely.
// - the secondary oscillator runs only while secondary_osc_enable is set.
// - a read-only ready flag shows the secondary oscillator is stable.
// - with ready set, a write selecting the secondary oscillator is taken and used.
`ifndef CLOCK_SELECT_REGS_SVH
`define CLOCK_SELECT_REGS_SVH

`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_TMR 8'h08

`define SEL_HI 1
`define SEL_LO 0
`define FREQ_HI 6
`define FREQ_LO 3
`define SECEN_BIT 0
`define STAT_START_BIT 0
`define STAT_RDY_BIT 1
`define STAT_SRC_HI 3
`define STAT_SRC_LO 2
`define STAT_BUSY_BIT 4

`define SEL_CFG 2'h0
`define SEL_SEC 2'h1
`define CFG_LOWPWR 3'h0
`define CFG_STD 3'h1
`define CFG_FAST 3'h2
`define CFG_INT 3'h4

`define SYNC_W 8
`define PIN_EXT 0
`define PIN_SEC 1
`define PIN_INT 2
`define PIN_FAIL 3
`define PIN_TWO 4
`define PIN_CFG_LO 5
`define PIN_CFG_HI 7
`define CFG_WAIT 2'h2

`define TMR_W 10
`define START_EDGES 10'h100
`define SEC_RDY_EDGES 10'h080
`define STAB_EDGES 10'h010

`endif

// ===== logic/clock_select_pkg.sv
// types of the system clock source selector
// assumes the register header is on the include path
`include "clock_select_regs.svh"
package clock_select_pkg;
  typedef enum logic [1:0] {SRC_CFG, SRC_SEC, SRC_INT} src_t;
  typedef enum logic {SW_RUN, SW_SETTLE} sw_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] sync1;
    logic [`SYNC_W-1:0] sync2;
    logic [1:0] cfg_wait;
    logic cfg_taken;
    logic [2:0] cfg_osc;
    logic two_speed;
    logic [1:0] sel;
    logic [3:0] freq;
    logic sec_en;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    src_t target;
    src_t active;
    src_t settle_src;
    sw_t sw;
    logic sys_clk;
    logic start_flag;
  } main_state_t;

  typedef struct packed {
    logic prev;
    logic [`TMR_W-1:0] cnt;
    logic done;
  } tmr_state_t;
endpackage : clock_select_pkg

// ===== logic/edge_timer_if.sv
// carrier between the selector and its edge-counting timers
// assumes all signals are on hclk
interface edge_timer_if;
  logic clr;
  logic lvl;
  logic done;
  modport timer (input clr, input lvl, output done);
  modport user (output clr, output lvl, input done);
endinterface : edge_timer_if

// ===== logic/edge_timer.sv
// counts rising edges of a synchronised oscillator level until a limit
// assumes lvl is already synchronised to hclk
`include "clock_select_regs.svh"
module edge_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [`TMR_W-1:0] limit,
  edge_timer_if.timer tif
);
  clock_select_pkg::tmr_state_t q;
  clock_select_pkg::tmr_state_t d;

  always_comb begin
    d = q;
    d.prev = tif.lvl;
    if (tif.clr) begin
      d.cnt = '0;
      d.done = 1'b0;
    end else if (tif.lvl && !q.prev && !q.done) begin
      d.cnt = q.cnt + `TMR_W'(1);
      d.done = (q.cnt + `TMR_W'(1)) == limit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.done = q.done;

  done_needs_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.done) |-> q.cnt == limit)
    else $error("timer done before limit reached");
  clr_drops_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tif.clr |=> !q.done && q.cnt == '0)
    else $error("timer not cleared");
endmodule : edge_timer

// ===== logic/clock_select.sv
// system clock source selector with AHB-Lite register access
// assumes oscillator levels and straps arrive as asynchronous pins; the
// multiplexed clock is rebuilt from their sampled levels on hclk
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`include "clock_select_regs.svh"
module clock_select (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ext_osc_clk,
  input wire logic secondary_osc_clk,
  input wire logic int_osc_clk,
  input wire logic fail_detect,
  input wire logic two_speed_enable,
  input wire logic [2:0] config_oscillator_select,
  output logic sys_clk,
  output logic [3:0] internal_freq_select,
  output logic secondary_osc_enable,
  output logic startup_timeout_flag,
  output logic secondary_osc_ready_flag
);
  clock_select_pkg::main_state_t q;
  clock_select_pkg::main_state_t d;
  logic [`SYNC_W-1:0] pins;
  logic take;
  logic crystal;
  logic hold_two;
  logic sys_nx;
  logic cfg_int;
  logic [31:0] rd_word;
  logic [1:0] unused_size;

  edge_timer_if start_if ();
  edge_timer_if sec_if ();
  edge_timer_if stab_if ();

  function automatic logic lvl(clock_select_pkg::src_t s, logic [`SYNC_W-1:0] v, logic use_int);
    logic r;
    r = v[`PIN_EXT];
    unique case (s)
      clock_select_pkg::SRC_SEC: r = v[`PIN_SEC];
      clock_select_pkg::SRC_INT: r = v[`PIN_INT];
      default: r = use_int ? v[`PIN_INT] : v[`PIN_EXT];
    endcase
    return r;
  endfunction : lvl

  assign pins = {config_oscillator_select, two_speed_enable, fail_detect,
                 int_osc_clk, secondary_osc_clk, ext_osc_clk};
  assign take = hsel && htrans[1] && hready;
  assign crystal = q.cfg_osc == `CFG_LOWPWR || q.cfg_osc == `CFG_STD || q.cfg_osc == `CFG_FAST;
  assign cfg_int = q.cfg_osc == `CFG_INT;
  assign hold_two = q.sel == `SEL_CFG && q.two_speed && crystal && !start_if.done;
  assign unused_size = hsize[1:0];

  // start-up timer runs on the configured oscillator only
  assign start_if.clr = !q.cfg_taken || !crystal;
  assign start_if.lvl = q.sync2[`PIN_EXT];
  assign sec_if.clr = !q.sec_en;
  assign sec_if.lvl = q.sync2[`PIN_SEC];
  assign stab_if.clr = q.sw != clock_select_pkg::SW_SETTLE || q.target != q.settle_src;
  assign stab_if.lvl = lvl(q.settle_src, q.sync2, cfg_int);

  edge_timer u_start_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .limit(`START_EDGES),
    .tif(start_if)
  );

  edge_timer u_sec_rdy (
    .hclk(hclk),
    .hresetn(hresetn),
    .limit(`SEC_RDY_EDGES),
    .tif(sec_if)
  );

  edge_timer u_stab (
    .hclk(hclk),
    .hresetn(hresetn),
    .limit(`STAB_EDGES),
    .tif(stab_if)
  );

  always_comb begin
    d = q;
    rd_word = '0;
    sys_nx = 1'b0;
    d.sync1 = pins;
    d.sync2 = q.sync1;
    // straps caught once the synchroniser has filled after reset
    if (!q.cfg_taken) begin
      if (q.cfg_wait == `CFG_WAIT) begin
        d.cfg_taken = 1'b1;
        d.cfg_osc = q.sync2[`PIN_CFG_HI:`PIN_CFG_LO];
        d.two_speed = q.sync2[`PIN_TWO];
      end else begin
        d.cfg_wait = q.cfg_wait + 2'h1;
      end
    end
    // bus data phase of a write
    d.wr_pend = take && hwrite;
    if (take) begin
      d.addr = haddr[7:0];
    end
    if (q.wr_pend) begin
      unique case (q.addr)
        `OFF_CTRL: begin
          d.sel = hwdata[`SEL_HI:`SEL_LO];
          d.freq = hwdata[`FREQ_HI:`FREQ_LO];
        end
        `OFF_TMR: d.sec_en = hwdata[`SECEN_BIT];
        default: d.sel = q.sel;
      endcase
    end
    // read word from the next state so a write just ahead is seen
    unique case (haddr[7:0])
      `OFF_CTRL: begin
        rd_word[`SEL_HI:`SEL_LO] = d.sel;
        rd_word[`FREQ_HI:`FREQ_LO] = d.freq;
      end
      `OFF_STAT: begin
        rd_word[`STAT_START_BIT] = q.start_flag;
        rd_word[`STAT_RDY_BIT] = sec_if.done;
        rd_word[`STAT_SRC_HI:`STAT_SRC_LO] = q.active;
        rd_word[`STAT_BUSY_BIT] = q.sw == clock_select_pkg::SW_SETTLE;
      end
      `OFF_TMR: rd_word[`SECEN_BIT] = d.sec_en;
      default: rd_word = '0;
    endcase
    if (take && !hwrite) begin
      d.hrdata = rd_word;
    end
    // automatic overrides steer the target only, never the select field
    if (fail_now() || hold_two || !q.cfg_taken) begin
      d.target = hold_two || fail_now() ? clock_select_pkg::SRC_INT : clock_select_pkg::SRC_CFG;
    end else if (q.sel[1]) begin
      d.target = clock_select_pkg::SRC_INT;
    end else if (q.sel == `SEL_SEC) begin
      d.target = clock_select_pkg::SRC_SEC;
    end else begin
      d.target = clock_select_pkg::SRC_CFG;
    end
    // break-before-make: park low, settle on the new source, join on its low phase
    unique case (q.sw)
      clock_select_pkg::SW_RUN: begin
        sys_nx = lvl(q.active, q.sync2, cfg_int);
        if (q.target != q.active && !sys_nx) begin
          d.sw = clock_select_pkg::SW_SETTLE;
          d.settle_src = q.target;
        end
      end
      clock_select_pkg::SW_SETTLE: begin
        if (q.target != q.settle_src) begin
          d.settle_src = q.target;
        end else if (stab_if.done && !lvl(q.settle_src, q.sync2, cfg_int)) begin
          d.active = q.settle_src;
          d.sw = clock_select_pkg::SW_RUN;
        end
      end
    endcase
    d.sys_clk = sys_nx;
    d.start_flag = q.active == clock_select_pkg::SRC_CFG && q.sw == clock_select_pkg::SW_RUN
                   && q.cfg_taken && !cfg_int && (!crystal || start_if.done);
  end

  function automatic logic fail_now();
    return q.sync2[`PIN_FAIL];
  endfunction : fail_now

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign sys_clk = q.sys_clk;
  assign internal_freq_select = q.freq;
  assign secondary_osc_enable = q.sec_en;
  assign startup_timeout_flag = q.start_flag;
  assign secondary_osc_ready_flag = sec_if.done;

  // helper: first cycle after reset release
  logic first_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  sequence park_seq;
    q.sw == clock_select_pkg::SW_RUN && q.target != q.active && !lvl(q.active, q.sync2, cfg_int);
  endsequence

  sequence join_seq;
    q.sw == clock_select_pkg::SW_SETTLE && q.target == q.settle_src && stab_if.done
      && !lvl(q.settle_src, q.sync2, cfg_int);
  endsequence

  sel_reset_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    first_q |-> q.sel == `SEL_CFG)
    else $error("select field not clear after reset");
  sel_write_taken_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && q.addr == `OFF_CTRL |=> q.sel == $past(hwdata[`SEL_HI:`SEL_LO]))
    else $error("select write not taken");
  sel_only_sw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(q.wr_pend && q.addr == `OFF_CTRL) |=> $stable(q.sel))
    else $error("select field changed without a write");
  freq_write_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.wr_pend && q.addr == `OFF_CTRL |=> internal_freq_select == $past(hwdata[`FREQ_HI:`FREQ_LO]))
    else $error("frequency select not driven out");
  two_speed_int_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.cfg_taken && hold_two |=> q.target == clock_select_pkg::SRC_INT)
    else $error("two-speed start-up did not target the internal oscillator");
  fail_safe_int_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.cfg_taken && fail_now() |=> q.target == clock_select_pkg::SRC_INT)
    else $error("fail-safe did not target the internal oscillator");
  cfg_target_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.cfg_taken && !fail_now() && !hold_two && q.sel == `SEL_CFG |=> q.target == clock_select_pkg::SRC_CFG)
    else $error("select 00 did not target the configured source");
  sec_target_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.cfg_taken && !fail_now() && q.sel == `SEL_SEC |=> q.target == clock_select_pkg::SRC_SEC)
    else $error("select 01 did not target the secondary oscillator");
  int_target_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.cfg_taken && q.sel[1] |=> q.target == clock_select_pkg::SRC_INT)
    else $error("select 1x did not target the internal oscillator");
  park_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    park_seq |=> q.sw == clock_select_pkg::SW_SETTLE && !q.sys_clk ##1 !q.sys_clk)
    else $error("clock not parked low on a switch");
  clk_rise_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(q.sys_clk) |-> $past(q.sw) == clock_select_pkg::SW_RUN)
    else $error("clock rose while switching");
  join_after_stab_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(q.active) |-> $past(stab_if.done))
    else $error("new source used before stabilisation");
  join_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    join_seq |=> q.sw == clock_select_pkg::SW_RUN && q.active == $past(q.settle_src))
    else $error("settled source not joined");
  start_flag_expiry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.start_flag && crystal |-> $past(start_if.done))
    else $error("start-up flag before timer expiry");
  start_flag_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.start_flag |-> $past(q.active) == clock_select_pkg::SRC_CFG && !cfg_int)
    else $error("start-up flag while not on configured source");
  sec_ready_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.sec_en |=> !secondary_osc_ready_flag)
    else $error("ready flag with oscillator disabled");
endmodule : clock_select

// ===== bench/osc_model.sv
// oscillator sources feeding the clock selector pins
// assumes the selector samples these levels on a much faster hclk
module osc_model #(
  parameter int EXT_HALF = 40,
  parameter int SEC_HALF = 100,
  parameter int INT_HALF = 30
) (
  input wire logic secondary_osc_enable,
  output logic ext_osc_clk,
  output logic secondary_osc_clk,
  output logic int_osc_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  // odd start offsets keep the sources out of phase with hclk
  initial begin
    ext_osc_clk = 1'h0;
    #7;
    forever #EXT_HALF ext_osc_clk = ~ext_osc_clk;
  end

  initial begin
    int_osc_clk = 1'h0;
    #3;
    forever #INT_HALF int_osc_clk = ~int_osc_clk;
  end

  // crystal amplifier stands still while disabled
  initial begin
    secondary_osc_clk = 1'h0;
    forever begin
      #SEC_HALF;
      if (secondary_osc_enable === 1'h1) secondary_osc_clk = ~secondary_osc_clk;
      else secondary_osc_clk = 1'h0;
    end
  end
endmodule : osc_model

// ===== bench/clock_select_tb_top.sv
// register-level bench of the clock selector over AHB-Lite
// assumes one slave on the bus, oscillators from osc_model, standard crystal strap
`include "clock_select_regs.svh"
module clock_select_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, fail_detect, hreadyout, hresp, sys_clk, sl;
  logic secondary_osc_enable, startup_timeout_flag, secondary_osc_ready_flag;
  logic ext_osc_clk, secondary_osc_clk, int_osc_clk, two_speed;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [3:0] internal_freq_select;
  int miscompares, samples_checked, ph, min_ph;

  clock_select u_clock_select (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ext_osc_clk(ext_osc_clk), .secondary_osc_clk(secondary_osc_clk),
    .int_osc_clk(int_osc_clk), .fail_detect(fail_detect), .two_speed_enable(two_speed),
    .config_oscillator_select(3'h1), .sys_clk(sys_clk), .internal_freq_select(internal_freq_select),
    .secondary_osc_enable(secondary_osc_enable), .startup_timeout_flag(startup_timeout_flag),
    .secondary_osc_ready_flag(secondary_osc_ready_flag));

  osc_model u_osc_model (.secondary_osc_enable(secondary_osc_enable), .ext_osc_clk(ext_osc_clk),
    .secondary_osc_clk(secondary_osc_clk), .int_osc_clk(int_osc_clk));

  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end

  // shortest sys_clk phase over the whole run; the phase count restarts at every reset
  always @(posedge hclk) begin
    sl <= sys_clk;
    if (!hresetn) ph <= 99;
    else if (sys_clk !== sl) ph <= 1;
    else ph <= ph + 1;
    if (hresetn && sys_clk !== sl && ph < min_ph) min_ph <= ph;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : ahb

  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
    do ahb(1'h0, `OFF_STAT, 32'h0, rd); while ((rd & mask) !== val);
  endtask : wait_stat

  // rise-to-rise sys_clk period in hclk cycles, within one cycle of e
  task automatic period(input int e);
    int c;
    logic p;
    c = -1;
    p = 1'h1;
    repeat (300) begin
      @(negedge hclk);
      if (c >= 0) c++;
      if (p === 1'h0 && sys_clk === 1'h1) begin
        if (c > 0) break;
        c = 0;
      end
      p = sys_clk;
    end
    check("sys_clk_period", 32'(c >= e - 1 && c <= e + 1), 32'h1);
  endtask : period

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    fail_detect = 1'h0;
    two_speed = 1'h0;
    min_ph = 99;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, `OFF_CTRL, 32'h0, rd);
    check("ctrl_reset", rd, 32'h0);
    check("start_early", 32'(startup_timeout_flag), 32'h0);
    ahb(1'h0, 32'h0C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    wait_stat(32'h1, 32'h1);
    ahb(1'h0, `OFF_STAT, 32'h0, rd);
    check("stat_cfg", rd, 32'h1);
    period(8);
    ahb(1'h1, `OFF_TMR, 32'h1, rd);
    wait_stat(32'h2, 32'h2);
    check("sec_enable", 32'(secondary_osc_enable), 32'h1);
    ahb(1'h1, `OFF_STAT, 32'h0, rd);
    ahb(1'h0, `OFF_STAT, 32'h0, rd);
    check("stat_ready", rd, 32'h3);
    ahb(1'h1, `OFF_CTRL, 32'h1, rd);
    repeat (8) @(posedge hclk);
    ahb(1'h0, `OFF_STAT, 32'h0, rd);
    check("switch_busy", rd & 32'h10, 32'h10);
    wait_stat(32'h1C, 32'h04);
    period(20);
    check("start_on_sec", 32'(startup_timeout_flag), 32'h0);
    ahb(1'h1, `OFF_CTRL, 32'h2A, rd);
    wait_stat(32'h1C, 32'h08);
    check("freq_out", 32'(internal_freq_select), 32'h5);
    period(6);
    ahb(1'h0, `OFF_CTRL, 32'h0, rd);
    check("ctrl_rb", rd, 32'h2A);
    ahb(1'h1, `OFF_CTRL, 32'h0, rd);
    wait_stat(32'h1D, 32'h01);
    ahb(1'h1, `OFF_TMR, 32'h0, rd);
    repeat (3) @(posedge hclk);
    check("ready_off", 32'(secondary_osc_ready_flag), 32'h0);
    fail_detect <= 1'h1;
    wait_stat(32'h1C, 32'h08);
    ahb(1'h0, `OFF_CTRL, 32'h0, rd);
    check("sel_kept", rd, 32'h0);
    check("start_failed", 32'(startup_timeout_flag), 32'h0);
    fail_detect <= 1'h0;
    wait_stat(32'h1D, 32'h01);
    ahb(1'h1, `OFF_CTRL, 32'h2, rd);
    repeat (6) @(posedge hclk);
    two_speed <= 1'h1;
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, `OFF_CTRL, 32'h0, rd);
    check("ctrl_rereset", rd, 32'h0);
    wait_stat(32'h1C, 32'h08);
    ahb(1'h0, `OFF_CTRL, 32'h0, rd);
    check("sel_two_speed", rd, 32'h0);
    wait_stat(32'h1D, 32'h01);
    period(8);
    check("min_phase", 32'(min_ph >= 2), 32'h1);
    end_sim();
  end

  initial begin
    #500us;
    miscompares++;
    end_sim();
  end
endmodule : clock_select_tb_top
